// >>> match_pwm_unit.sv
// Timer with prescaler, seven match registers and six PWM outputs
// Functional notes
// - 32-bit counter behind 32-bit prescaler
// - Count clock: bus clock or capture input edges
// - Seven matches; six single or three double outputs
// - Match may continue, stop or reset; interrupt optional
// - Match zero resets counter, sets shared period
// - Single-edge output: period match plus one match
// - Extra single-edge output costs one match
// - Single-edge outputs rise at period match
// - Double-edge output: period plus set and clear
// - Extra double-edge output costs two matches
// - Edges anywhere; order gives pulse polarity
// - Double-edge output positive or negative pulse
// - Period and width in whole counts
// - In PWM mode new matches apply only at cycle boundary
// - Without PWM mode acts as plain timer
// - Two units start together, master and slave
// - Matches switch pins and raise interrupts
`timescale 1ns/1ps
module match_pwm_unit #(
  parameter int NCAP = 2
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic [NCAP-1:0] cap_in,
  input wire logic sync_in,
  output logic sync_out,
  output logic [5:0] pwm_out,
  output logic [5:0] pwm_oe,
  output logic irq
);

  localparam int NF = pwm_pkg::FLAG_CAP_LO + NCAP;

  if (NCAP < 1 || NCAP > 4)
    $error("NCAP must lie between 1 and 4");

  // ----------------------------------------
  // Registers and bus front end
  // ----------------------------------------
  logic [NF-1:0] flags_r;
  logic [pwm_pkg::CTL_W-1:0] ctl_r;
  logic [31:0] tc_r;
  logic [31:0] pr_r;
  logic [31:0] pc_r;
  logic [3*pwm_pkg::NMATCH-1:0] mcr_r;
  logic [3:0] cnt_ctl_r;
  logic [pwm_pkg::OC_W-1:0] oc_r;
  logic [3*NCAP-1:0] ccr_r;
  logic [31:0] cap_r [NCAP];
  logic [NCAP-1:0] cap_prev_r;
  logic [6:1] out_r;
  logic started_r;
  logic en_prev_r;
  logic [31:0] shadow [pwm_pkg::NMATCH];
  logic [31:0] act [pwm_pkg::NMATCH];
  logic [pwm_pkg::NMATCH-1:0] ler;
  logic [pwm_pkg::NMATCH-1:0] hit;
  logic [31:0] rd_word [64];
  logic wr_en;
  logic [7:0] wr_addr;
  logic [31:0] wr_data;
  logic [3:0] wr_strb;
  logic [31:0] rd_data;

  axil_slave u_bus (
    .aclk(aclk),
    .aresetn(aresetn),
    .awaddr(s_axi_awaddr),
    .awvalid(s_axi_awvalid),
    .awready(s_axi_awready),
    .wdata(s_axi_wdata),
    .wstrb(s_axi_wstrb),
    .wvalid(s_axi_wvalid),
    .wready(s_axi_wready),
    .bresp(s_axi_bresp),
    .bvalid(s_axi_bvalid),
    .bready(s_axi_bready),
    .araddr(s_axi_araddr),
    .arvalid(s_axi_arvalid),
    .arready(s_axi_arready),
    .rdata(s_axi_rdata),
    .rresp(s_axi_rresp),
    .rvalid(s_axi_rvalid),
    .rready(s_axi_rready),
    .wr_en(wr_en),
    .wr_addr(wr_addr),
    .wr_data(wr_data),
    .wr_strb(wr_strb),
    .rd_en(),
    .rd_data(rd_data)
  );

  // Read view; unmapped words read zero
  always_comb
  begin
    rd_word = '{default: pwm_pkg::RST_WORD};
    rd_word[pwm_pkg::OFS_FLAGS[7:2]] = 32'(flags_r);
    rd_word[pwm_pkg::OFS_CTL[7:2]] = 32'(ctl_r);
    rd_word[pwm_pkg::OFS_COUNT[7:2]] = tc_r;
    rd_word[pwm_pkg::OFS_PRESCALE[7:2]] = pr_r;
    rd_word[pwm_pkg::OFS_PRE_CNT[7:2]] = pc_r;
    rd_word[pwm_pkg::OFS_MATCH_CTL[7:2]] = 32'(mcr_r);
    rd_word[pwm_pkg::OFS_CNT_CTL[7:2]] = 32'(cnt_ctl_r);
    rd_word[pwm_pkg::OFS_OUT_CTL[7:2]] = 32'(oc_r);
    rd_word[pwm_pkg::OFS_LATCH_EN[7:2]] = 32'(ler);
    rd_word[pwm_pkg::OFS_CAP_CTL[7:2]] = 32'(ccr_r);
    for (int i = 0; i < pwm_pkg::NMATCH; i++)
      rd_word[6'(pwm_pkg::OFS_MATCH0[7:2] + i)] = shadow[i];
    for (int j = 0; j < NCAP; j++)
      rd_word[6'(pwm_pkg::OFS_CAP0[7:2] + j)] = cap_r[j];
  end

  wire [5:0] widx = wr_addr[7:2];
  wire [31:0] bmask = {{8{wr_strb[3]}}, {8{wr_strb[2]}},
                       {8{wr_strb[1]}}, {8{wr_strb[0]}}};
  wire [31:0] wval = (rd_word[widx] & ~bmask) | (wr_data & bmask);
  wire [31:0] wclr = wr_data & bmask;
  assign rd_data = rd_word[s_axi_araddr[7:2]];

  wire wr_flags = wr_en && widx == pwm_pkg::OFS_FLAGS[7:2];
  wire wr_ctl = wr_en && widx == pwm_pkg::OFS_CTL[7:2];
  wire wr_count = wr_en && widx == pwm_pkg::OFS_COUNT[7:2];
  wire wr_pre = wr_en && widx == pwm_pkg::OFS_PRESCALE[7:2];
  wire wr_pc = wr_en && widx == pwm_pkg::OFS_PRE_CNT[7:2];
  wire wr_mcr = wr_en && widx == pwm_pkg::OFS_MATCH_CTL[7:2];
  wire wr_cnt_ctl = wr_en && widx == pwm_pkg::OFS_CNT_CTL[7:2];
  wire wr_oc = wr_en && widx == pwm_pkg::OFS_OUT_CTL[7:2];
  wire wr_ler = wr_en && widx == pwm_pkg::OFS_LATCH_EN[7:2];
  wire wr_ccr = wr_en && widx == pwm_pkg::OFS_CAP_CTL[7:2];

  // ----------------------------------------
  // Count source and prescaler
  // ----------------------------------------
  wire pwm_on = ctl_r[pwm_pkg::CTL_PWM];
  wire [1:0] cnt_sel = cnt_ctl_r[3:2];
  wire [3:0] cap_pad = 4'(cap_in);
  wire [3:0] prev_pad = 4'(cap_prev_r);
  wire src_rise = cap_pad[cnt_sel] && !prev_pad[cnt_sel];
  wire src_fall = !cap_pad[cnt_sel] && prev_pad[cnt_sel];
  pwm_pkg::cnt_mode_e cnt_mode;
  assign cnt_mode = pwm_pkg::cnt_mode_e'(cnt_ctl_r[1:0]);
  wire cnt_edge = (cnt_mode == pwm_pkg::CNT_TIMER) ||
                  (cnt_mode == pwm_pkg::CNT_RISE && src_rise) ||
                  (cnt_mode == pwm_pkg::CNT_FALL && src_fall) ||
                  (cnt_mode == pwm_pkg::CNT_BOTH && (src_rise || src_fall));
  // Slave holds off until the master start pulse arrives
  wire run = ctl_r[pwm_pkg::CTL_EN] && !ctl_r[pwm_pkg::CTL_RST] &&
             (!ctl_r[pwm_pkg::CTL_SLAVE] || started_r);
  wire pre_tick = run && cnt_edge;
  wire tick = pre_tick && (pc_r == pr_r);

  // ----------------------------------------
  // Match channels and actions
  // ----------------------------------------
  logic [pwm_pkg::NMATCH-1:0] m_int;
  logic [pwm_pkg::NMATCH-1:0] m_rst;
  logic [pwm_pkg::NMATCH-1:0] m_stop;

  for (genvar i = 0; i < pwm_pkg::NMATCH; i++)
  begin : g_match
    assign m_int[i] = mcr_r[pwm_pkg::MC_W*i + pwm_pkg::MC_INT];
    assign m_rst[i] = mcr_r[pwm_pkg::MC_W*i + pwm_pkg::MC_RST];
    assign m_stop[i] = mcr_r[pwm_pkg::MC_W*i + pwm_pkg::MC_STOP];
    match_channel u_ch (
      .aclk(aclk),
      .aresetn(aresetn),
      .wr_en(wr_en && widx == 6'(pwm_pkg::OFS_MATCH0[7:2] + i)),
      .wr_val(wval),
      .ler_set(wr_ler && wval[i]),
      .direct(!pwm_on),
      .upd(hit[0]),
      .tick(tick),
      .count(tc_r),
      .shadow(shadow[i]),
      .active(act[i]),
      .ler(ler[i]),
      .hit(hit[i])
    );
  end

  // Match zero always closes the cycle in PWM mode
  wire rst_hit = |(hit & m_rst) || (pwm_on && hit[0]);
  wire stop_hit = |(hit & m_stop);

  // ----------------------------------------
  // Capture channels
  // ----------------------------------------
  logic [NCAP-1:0] cap_ev;
  for (genvar j = 0; j < NCAP; j++)
  begin : g_cap
    assign cap_ev[j] =
      (ccr_r[pwm_pkg::CC_W*j + pwm_pkg::CC_RISE] &&
       cap_in[j] && !cap_prev_r[j]) ||
      (ccr_r[pwm_pkg::CC_W*j + pwm_pkg::CC_FALL] &&
       !cap_in[j] && cap_prev_r[j]);
    always_ff @(posedge aclk)
    begin
      if (!aresetn)
        cap_r[j] <= pwm_pkg::RST_WORD;
      else if (cap_ev[j])
        cap_r[j] <= tc_r;
    end
  end

  logic [NCAP-1:0] cap_int;
  for (genvar j = 0; j < NCAP; j++)
  begin : g_cint
    assign cap_int[j] = cap_ev[j] && ccr_r[pwm_pkg::CC_W*j + pwm_pkg::CC_INT];
  end

  // Hardware set wins over a software clear in the same cycle
  wire [NF-1:0] flag_set = {cap_int, hit & m_int};
  assign irq = |flags_r;

  // ----------------------------------------
  // PWM output edges
  // ----------------------------------------
  logic [6:1] pwm_set;
  logic [6:1] pwm_clr;
  assign pwm_set[1] = hit[0];
  assign pwm_clr[1] = hit[1];
  for (genvar n = 2; n <= pwm_pkg::NOUT; n++)
  begin : g_edge
    assign pwm_set[n] = oc_r[n] ? hit[n-1] : hit[0];
    assign pwm_clr[n] = hit[n];
  end
  assign pwm_out = out_r;
  assign pwm_oe = oc_r[pwm_pkg::OC_OE_LO +: 6] & {6{pwm_on}};

  // ----------------------------------------
  // State update
  // ----------------------------------------
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      flags_r <= '0;
      ctl_r <= '0;
      tc_r <= pwm_pkg::RST_WORD;
      pr_r <= pwm_pkg::RST_WORD;
      pc_r <= pwm_pkg::RST_WORD;
      mcr_r <= '0;
      cnt_ctl_r <= 4'h0;
      oc_r <= '0;
      ccr_r <= '0;
      cap_prev_r <= '0;
      out_r <= '0;
      started_r <= 1'b0;
      en_prev_r <= 1'b0;
      sync_out <= 1'b0;
    end
    else
    begin
      flags_r <= (flags_r & ~(wr_flags ? wclr[NF-1:0] : '0)) | flag_set;
      if (wr_ctl)
        ctl_r <= wval[pwm_pkg::CTL_W-1:0];
      else if (stop_hit)
        ctl_r[pwm_pkg::CTL_EN] <= 1'b0;
      if (ctl_r[pwm_pkg::CTL_RST])
        tc_r <= pwm_pkg::RST_WORD;
      else if (wr_count)
        tc_r <= wval;
      else if (tick)
        tc_r <= rst_hit ? pwm_pkg::RST_WORD : tc_r + 32'd1;
      if (ctl_r[pwm_pkg::CTL_RST] || (pre_tick && pc_r == pr_r))
        pc_r <= pwm_pkg::RST_WORD;
      else if (wr_pc)
        pc_r <= wval;
      else if (pre_tick)
        pc_r <= pc_r + 32'd1;
      if (wr_pre)
        pr_r <= wval;
      if (wr_mcr)
        mcr_r <= wval[3*pwm_pkg::NMATCH-1:0];
      if (wr_cnt_ctl)
        cnt_ctl_r <= wval[3:0];
      if (wr_oc)
        oc_r <= wval[pwm_pkg::OC_W-1:0];
      if (wr_ccr)
        ccr_r <= wval[3*NCAP-1:0];
      cap_prev_r <= cap_in;
      // Clear beats set so a match equal to the period stays low
      for (int n = 1; n <= pwm_pkg::NOUT; n++)
        out_r[n] <= pwm_on && !pwm_clr[n] && (pwm_set[n] || out_r[n]);
      en_prev_r <= ctl_r[pwm_pkg::CTL_EN];
      sync_out <= ctl_r[pwm_pkg::CTL_EN] && !en_prev_r;
      started_r <= ctl_r[pwm_pkg::CTL_EN] && (sync_in || started_r);
    end
  end

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);

  chk_prescale_wrap: assert property (
    tick && !wr_en && !ctl_r[pwm_pkg::CTL_RST] && !rst_hit
    |=> pc_r == 32'd0 && tc_r == $past(tc_r) + 32'd1)
    else $error("prescaler wrap did not advance counter");

  chk_timer_source: assert property (
    run && cnt_mode == pwm_pkg::CNT_TIMER && pc_r != pr_r && !wr_en
    |=> pc_r == $past(pc_r) + 32'd1)
    else $error("timer mode missed a bus clock");

  chk_stop_match: assert property (
    stop_hit && !wr_en |=> !ctl_r[pwm_pkg::CTL_EN] ##1 $stable(tc_r) [*2])
    else $error("stop on match did not halt counter");

  chk_period_reset: assert property (
    pwm_on && hit[0] && !wr_en && !ctl_r[pwm_pkg::CTL_RST] |=> tc_r == 32'd0)
    else $error("period match did not reset counter");

  chk_single_rise: assert property (
    pwm_on && hit[0] && !hit[1] |=> pwm_out[0])
    else $error("single edge output did not rise at period");

  chk_single_fall: assert property (
    pwm_on && hit[1] ##1 !hit[0] [*2] |-> !pwm_out[0] && !$past(pwm_out[0]))
    else $error("single edge output did not fall at match");

  chk_double_set: assert property (
    pwm_on && oc_r[2] && hit[1] && !hit[2] |=> pwm_out[1])
    else $error("double edge output did not rise at its match");

  chk_latch_hold: assert property (
    pwm_on && !hit[0] && !wr_ctl |=> act[1] == $past(act[1]))
    else $error("match value changed mid cycle");

  chk_flag_sticky: assert property (
    hit[0] && m_int[0] |=> flags_r[0] && irq)
    else $error("match event did not raise flag");

  chk_slave_wait: assert property (
    ctl_r[pwm_pkg::CTL_SLAVE] && !started_r |-> !tick)
    else $error("slave counted before start pulse");

endmodule // match_pwm_unit

// >>> pwm_pkg.sv
// Shared constants for the match based PWM unit
package pwm_pkg;

  // ----------------------------------------
  // Sizes
  // ----------------------------------------
  localparam int NMATCH = 7;
  localparam int NOUT = 6;
  localparam int AW = 8;

  // ----------------------------------------
  // Register byte offsets
  // ----------------------------------------
  localparam logic [7:0] OFS_FLAGS = 8'h00;
  localparam logic [7:0] OFS_CTL = 8'h04;
  localparam logic [7:0] OFS_COUNT = 8'h08;
  localparam logic [7:0] OFS_PRESCALE = 8'h0C;
  localparam logic [7:0] OFS_PRE_CNT = 8'h10;
  localparam logic [7:0] OFS_MATCH_CTL = 8'h14;
  localparam logic [7:0] OFS_MATCH0 = 8'h18;
  localparam logic [7:0] OFS_CNT_CTL = 8'h34;
  localparam logic [7:0] OFS_OUT_CTL = 8'h38;
  localparam logic [7:0] OFS_LATCH_EN = 8'h3C;
  localparam logic [7:0] OFS_CAP_CTL = 8'h40;
  localparam logic [7:0] OFS_CAP0 = 8'h44;

  // ----------------------------------------
  // Field positions
  // ----------------------------------------
  localparam int CTL_EN = 0;
  localparam int CTL_RST = 1;
  localparam int CTL_PWM = 3;
  localparam int CTL_SLAVE = 4;
  localparam int CTL_W = 5;
  localparam int MC_INT = 0;
  localparam int MC_RST = 1;
  localparam int MC_STOP = 2;
  localparam int MC_W = 3;
  localparam int OC_OE_LO = 9;
  localparam int OC_W = 15;
  localparam int CC_RISE = 0;
  localparam int CC_FALL = 1;
  localparam int CC_INT = 2;
  localparam int CC_W = 3;
  localparam int FLAG_CAP_LO = 7;

  // ----------------------------------------
  // Reset values and encodings
  // ----------------------------------------
  localparam logic [31:0] RST_WORD = 32'h0000_0000;
  localparam logic [1:0] AXI_OKAY = 2'b00;

  typedef enum logic [1:0] {
    CNT_TIMER = 2'b00,
    CNT_RISE = 2'b01,
    CNT_FALL = 2'b10,
    CNT_BOTH = 2'b11
  } cnt_mode_e;

endpackage

// >>> match_channel.sv
// One match register with its shadow, release bit and comparator
`timescale 1ns/1ps
module match_channel (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic wr_en,
  input wire logic [31:0] wr_val,
  input wire logic ler_set,
  input wire logic direct,
  input wire logic upd,
  input wire logic tick,
  input wire logic [31:0] count,
  output logic [31:0] shadow,
  output logic [31:0] active,
  output logic ler,
  output logic hit
);

  assign hit = tick && (count == active);

  // In PWM mode the shadow only reaches the comparator at a cycle boundary once released; otherwise it passes straight through
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      shadow <= pwm_pkg::RST_WORD;
      active <= pwm_pkg::RST_WORD;
      ler <= 1'b0;
    end
    else
    begin
      if (wr_en)
        shadow <= wr_val;
      if (direct)
        active <= wr_en ? wr_val : shadow;
      else if (upd && ler)
        active <= shadow;
      ler <= ler_set || (ler && !(upd && !direct));
    end
  end

endmodule // match_channel

// >>> axil_slave.sv
// AXI4-Lite slave front end, one write and one read in flight
`timescale 1ns/1ps
module axil_slave (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [7:0] awaddr,
  input wire logic awvalid,
  output logic awready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  input wire logic [7:0] araddr,
  input wire logic arvalid,
  output logic arready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready,
  output logic wr_en,
  output logic [7:0] wr_addr,
  output logic [31:0] wr_data,
  output logic [3:0] wr_strb,
  output logic rd_en,
  input wire logic [31:0] rd_data
);

  logic aw_hold_r;
  logic w_hold_r;
  logic [7:0] addr_r;
  logic [31:0] data_r;
  logic [3:0] strb_r;
  wire aw_got = aw_hold_r || (awvalid && awready);
  wire w_got = w_hold_r || (wvalid && wready);

  assign awready = !aw_hold_r && !bvalid;
  assign wready = !w_hold_r && !bvalid;
  assign wr_en = aw_got && w_got && !bvalid;
  assign wr_addr = aw_hold_r ? addr_r : awaddr;
  assign wr_data = w_hold_r ? data_r : wdata;
  assign wr_strb = w_hold_r ? strb_r : wstrb;
  assign arready = !rvalid;
  assign rd_en = arvalid && arready;
  assign bresp = pwm_pkg::AXI_OKAY;
  assign rresp = pwm_pkg::AXI_OKAY;

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      aw_hold_r <= 1'b0;
      w_hold_r <= 1'b0;
      addr_r <= 8'h00;
      data_r <= pwm_pkg::RST_WORD;
      strb_r <= 4'h0;
      bvalid <= 1'b0;
      rvalid <= 1'b0;
      rdata <= pwm_pkg::RST_WORD;
    end
    else
    begin
      aw_hold_r <= aw_got && !wr_en;
      w_hold_r <= w_got && !wr_en;
      if (awvalid && awready)
        addr_r <= awaddr;
      if (wvalid && wready)
      begin
        data_r <= wdata;
        strb_r <= wstrb;
      end
      bvalid <= wr_en || (bvalid && !bready);
      rvalid <= rd_en || (rvalid && !rready);
      if (rd_en)
        rdata <= rd_data;
    end
  end

endmodule // axil_slave

// >>> pwm_load.sv
// Load model that totals the high time of each PWM pin
`timescale 1ns/1ps
module pwm_load (
  input wire logic aclk,
  input wire logic [5:0] pwm_out,
  input wire logic [5:0] pwm_oe,
  input wire logic start,
  input wire logic [15:0] span,
  output logic [5:0][15:0] high_cnt,
  output logic busy
);
  // ----------------------------------------
  // Window counter
  // ----------------------------------------
  logic [15:0] left_r = 16'h0000;
  // Released pin falls to its pull-down, so it counts as low
  wire logic [5:0] lvl = pwm_out & pwm_oe;
  assign busy = (left_r != 16'h0000);
  always_ff @(posedge aclk)
  begin
    if (start)
    begin
      left_r <= span;
      high_cnt <= '0;
    end
    else if (busy)
    begin
      left_r <= left_r - 16'h0001;
      for (int i = 0; i < 6; i++)
        high_cnt[i] <= high_cnt[i] + {15'h0000, lvl[i]};
    end
  end
endmodule // pwm_load

// >>> tb.sv
// Self-checking bench for the match based PWM unit
`timescale 1ns/1ps
module tb;
  // ----------------------------------------
  // Signals
  // ----------------------------------------
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic [7:0] awaddr = 8'h00;
  logic awvalid = 1'b0;
  logic [31:0] wdata = 32'h0000_0000;
  logic wvalid = 1'b0;
  logic bready = 1'b0;
  logic [7:0] araddr = 8'h00;
  logic arvalid = 1'b0;
  logic rready = 1'b0;
  logic [1:0] cap_in = 2'b00;
  logic sync_in = 1'b0;
  logic awready, wready, bvalid, arready, rvalid, sync_out, irq, busy;
  logic [1:0] bresp, rresp, pre, opre;
  logic [31:0] rdata, rd, c1;
  logic [5:0] pwm_out, pwm_oe, dbl, odbl;
  logic start = 1'b0;
  logic [15:0] span = 16'h0000;
  logic [5:0][15:0] high_cnt;
  logic [15:0] mv [7];
  logic [15:0] ov [7];
  logic [31:0] seed = 32'h3493_2877;
  int bad_count = 0;
  int comparisons = 0;
  int sync_seen = 0;
  int n, s0, md;
  always #12.5 aclk = ~aclk;
  always @(posedge aclk) if (sync_out === 1'b1) sync_seen++;

  match_pwm_unit #(.NCAP(2)) u_dut (
    .aclk(aclk), .aresetn(aresetn),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
    .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
    .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
    .s_axi_rvalid(rvalid), .s_axi_rready(rready), .cap_in(cap_in),
    .sync_in(sync_in), .sync_out(sync_out), .pwm_out(pwm_out),
    .pwm_oe(pwm_oe), .irq(irq)
  );
  pwm_load u_load (
    .aclk(aclk), .pwm_out(pwm_out), .pwm_oe(pwm_oe), .start(start),
    .span(span), .high_cnt(high_cnt), .busy(busy)
  );

  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction
  // High counts per period from set position s and clear position c
  function automatic logic [15:0] width(input logic [15:0] s, c, m);
    if (s == c)
      return 16'h0000;
    if (s < c)
      return c - s;
    return m + 16'h0001 - (s - c);
  endfunction
  task automatic report_and_stop();
    $display("counts: %0d compared, %0d mismatched", comparisons, bad_count);
    if (bad_count == 0 && comparisons > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  task automatic check(input string what, input logic [31:0] e, g);
    comparisons++;
    if (g !== e)
    begin
      bad_count++;
      $display("MISMATCH %s expected %h seen %h", what, e, g);
    end
  endtask
  task automatic hung();
    bad_count++;
    $display("MISMATCH wait expected answer seen timeout");
    report_and_stop();
  endtask
  task automatic cyc(input int k);
    repeat (k) @(posedge aclk);
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    int k;
    k = 0;
    @(posedge aclk);
    awaddr <= a;
    awvalid <= 1'b1;
    wdata <= d;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do
    begin
      @(posedge aclk);
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
      k++;
      if (k > 200) hung();
    end
    while (bvalid !== 1'b1);
    bready <= 1'b0;
    check("bresp", 32'(pwm_pkg::AXI_OKAY), 32'(bresp));
  endtask
  task automatic rchk(input string what, input logic [7:0] a,
    input logic [31:0] e);
    int k;
    k = 0;
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do
    begin
      @(posedge aclk);
      if (arvalid && arready) arvalid <= 1'b0;
      k++;
      if (k > 200) hung();
    end
    while (rvalid !== 1'b1);
    rd = rdata;
    rready <= 1'b0;
    check("rresp", 32'(pwm_pkg::AXI_OKAY), 32'(rresp));
    if (what != "") check(what, e, rd);
  endtask
  task automatic put_matches(input logic [15:0] v [7]);
    for (int i = 0; i < 7; i++)
      wr(pwm_pkg::OFS_MATCH0 + 8'(4 * i), {16'h0000, v[i]});
  endtask
  task automatic measure(input string what, input logic [15:0] v [7],
    input logic [5:0] d, input logic [1:0] p);
    int k;
    logic [15:0] s;
    logic [31:0] f;
    f = 32'h0000_0002 * ({30'h0, p} + 32'h0000_0001);
    @(posedge aclk);
    span <= f[15:0] * (v[0] + 16'h0001);
    start <= 1'b1;
    @(posedge aclk);
    start <= 1'b0;
    k = 0;
    do
    begin
      @(posedge aclk);
      k++;
    end
    while (busy && k < 2000);
    if (k >= 2000) hung();
    for (int i = 0; i < 6; i++)
    begin
      s = d[i] ? v[i] : v[0];
      check(what, {16'h0000, width(s, v[i + 1], v[0])} * f, {16'h0000, high_cnt[i]});
    end
  endtask

  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  initial
  begin
    repeat (16) @(posedge aclk);
    aresetn <= 1'b1;
    rchk("ctl", pwm_pkg::OFS_CTL, 32'h0000_0000);
    rchk("latch", pwm_pkg::OFS_LATCH_EN, 32'h0000_0000);
    wr(8'hF0, 32'h1234_5678);
    rchk("unmapped", 8'hF0, 32'h0000_0000);
    check("idle", 32'h0000_0000, {25'h0, irq, pwm_out});
    $display("test reset done");
    // Far matches keep their flags quiet while match zero wraps
    for (int i = 1; i < 7; i++)
      wr(pwm_pkg::OFS_MATCH0 + 8'(4 * i), 32'hFFFF_FFFF);
    n = 4 + int'(rnd() % 8);
    wr(pwm_pkg::OFS_CTL, 32'h0000_0002);
    wr(pwm_pkg::OFS_MATCH_CTL, 32'h0000_0003);
    wr(pwm_pkg::OFS_MATCH0, n);
    wr(pwm_pkg::OFS_OUT_CTL, 32'h0000_7E00);
    wr(pwm_pkg::OFS_CTL, 32'h0000_0001);
    cyc(3 * n + 10);
    rchk("flag", pwm_pkg::OFS_FLAGS, 32'h0000_0001);
    check("irq", 32'h0000_0001, {31'h0, irq});
    check("oe", 32'h0000_0000, {20'h0, pwm_oe, pwm_out});
    rchk("", pwm_pkg::OFS_COUNT, 32'h0000_0000);
    check("wrap", 32'h0000_0001, {31'h0, rd <= n});
    wr(pwm_pkg::OFS_CTL, 32'h0000_0000);
    wr(pwm_pkg::OFS_FLAGS, 32'h0000_0001);
    rchk("clear", pwm_pkg::OFS_FLAGS, 32'h0000_0000);
    check("irq_off", 32'h0000_0000, {31'h0, irq});
    wr(pwm_pkg::OFS_MATCH_CTL, 32'h0000_0020);
    wr(pwm_pkg::OFS_MATCH0 + 8'h04, n);
    wr(pwm_pkg::OFS_CTL, 32'h0000_0002);
    wr(pwm_pkg::OFS_CTL, 32'h0000_0001);
    cyc(n + 20);
    rchk("stop_en", pwm_pkg::OFS_CTL, 32'h0000_0000);
    rchk("", pwm_pkg::OFS_COUNT, 32'h0000_0000);
    c1 = rd;
    rchk("", pwm_pkg::OFS_COUNT, 32'h0000_0000);
    check("stop_cnt", 32'h0000_0001, {31'h0, rd == c1 && c1 >= n && c1 <= n + 1});
    $display("test timer done");
    wr(pwm_pkg::OFS_MATCH_CTL, 32'h0000_0000);
    wr(pwm_pkg::OFS_PRESCALE, 32'h0000_0000);
    // Capture 0 on rising edges with its flag, count mode drawn at random
    wr(pwm_pkg::OFS_CAP_CTL, 32'h0000_0005);
    md = 1 + int'(rnd() % 3);
    wr(pwm_pkg::OFS_CNT_CTL, md);
    wr(pwm_pkg::OFS_CTL, 32'h0000_0002);
    wr(pwm_pkg::OFS_CTL, 32'h0000_0001);
    n = 3 + int'(rnd() % 6);
    repeat (n)
    begin
      @(posedge aclk) cap_in <= 2'b11;
      cyc(3);
      @(posedge aclk) cap_in <= 2'b00;
      cyc(3);
    end
    rchk("edges", pwm_pkg::OFS_COUNT, (md == 3) ? 2 * n : n);
    rchk("capture", pwm_pkg::OFS_CAP0, (md == 3) ? 2 * n - 2 : n - 1);
    rchk("cap_flag", pwm_pkg::OFS_FLAGS, 32'h0000_0080);
    wr(pwm_pkg::OFS_FLAGS, 32'h0000_0080);
    wr(pwm_pkg::OFS_CNT_CTL, 32'h0000_0000);
    wr(pwm_pkg::OFS_CTL, 32'h0000_0002);
    s0 = sync_seen;
    wr(pwm_pkg::OFS_CTL, 32'h0000_0011);
    cyc(20);
    check("sync_out", s0 + 1, sync_seen);
    rchk("slave_wait", pwm_pkg::OFS_COUNT, 32'h0000_0000);
    @(posedge aclk) sync_in <= 1'b1;
    @(posedge aclk) sync_in <= 1'b0;
    cyc(10);
    rchk("", pwm_pkg::OFS_COUNT, 32'h0000_0000);
    check("slave_run", 32'h0000_0001, {31'h0, rd != 0});
    $display("test counter and sync done");
    // Corner: negative pulse on output 6, constant low on output 4
    mv = '{16'h000A, 16'h0003, 16'h0007, 16'h0002, 16'h000A, 16'h0006, 16'h0001};
    dbl = 6'b100010;
    pre = 2'b00;
    for (int r = 0; r < 5; r++)
    begin
      wr(pwm_pkg::OFS_CTL, 32'h0000_000A);
      wr(pwm_pkg::OFS_PRESCALE, {30'h0, pre});
      wr(pwm_pkg::OFS_OUT_CTL, 32'h0000_7E00 | {25'h0, dbl, 1'b0});
      put_matches(mv);
      wr(pwm_pkg::OFS_LATCH_EN, 32'h0000_007F);
      wr(pwm_pkg::OFS_CTL, 32'h0000_0009);
      cyc(400);
      check("pwm_oe", 32'h0000_003F, {26'h0, pwm_oe});
      measure("width", mv, dbl, pre);
      rchk("latch_clr", pwm_pkg::OFS_LATCH_EN, 32'h0000_0000);
      ov = mv;
      odbl = dbl;
      opre = pre;
      mv[0] = 16'h0008 + 16'(rnd() % 32);
      for (int i = 1; i < 7; i++)
        mv[i] = 16'(rnd() % (mv[0] + 16'h0001));
      dbl = 6'(rnd()) & 6'h3E;
      pre = 2'(rnd());
      put_matches(mv);
      cyc(400);
      measure("held", ov, odbl, opre);
      $display("test pwm round %0d done", r);
    end
    report_and_stop();
  end
endmodule // tb
